// [logic/tch_pkg.sv]
// Shared constants and types for the two-stage configuration handoff
package tch_pkg;
    localparam int CLK_MHZ = 50;
    localparam int RDY_MIN_CYC = 2;
    localparam int RDY_MAX_CYC = 12;
    localparam int BAR0_MBYTE = 128;
    localparam logic [31:0] BAR0_LIMIT = 32'(BAR0_MBYTE * 1024 * 1024);
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WCOUNT = 8'h08;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_FWD_EN = 0;
    localparam int ST_RDY_BIT = 0;
    localparam int ST_LNK_BIT = 1;
    localparam int ST_BOOT_BIT = 2;
    localparam int ST_STATE_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int STARTUP_DRV_W = 8;
    localparam int STARTUP_OBS_W = 5;
    localparam int BOOT_FLAG_IDX = 0;
    localparam logic [3:0] CNT_RESET = 4'h0;

    typedef enum logic [1:0] {
        K_MEM_RD = 2'b00,
        K_MEM_WR = 2'b01,
        K_VDM    = 2'b10,
        K_OTHER  = 2'b11
    } tch_kind_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WR   = 3'b001,
        S_DROP = 3'b010,
        S_CPL  = 3'b011,
        S_OFF  = 3'b100
    } tch_state_e;

    // One receive beat; header beats carry kind and address, data beats data
    typedef struct packed {
        tch_kind_e   kind;
        logic        bar0_hit;
        logic        last;
        logic [7:0]  tag;
        logic [15:0] req_id;
        logic [31:0] addr;
        logic [31:0] data;
    } tch_rx_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  tag;
        logic [15:0] req_id;
        logic [31:0] data;
    } tch_cpl_s;

    // Critical core inputs that must read as deasserted before handoff
    typedef struct packed {
        logic tx_valid;
        logic tx_last;
        logic rx_ready;
        logic cfg_req;
        logic intr_req;
        logic pm_req;
    } tch_crit_s;

    // Configuration access port: select, direction and write data (read data comes back on icap_rdata)
    typedef struct packed {
        logic        sel_n;
        logic        rd_n;
        logic [31:0] wdata;
    } tch_icap_s;
endpackage : tch_pkg

// [logic/tch_sync3.sv]
// Three-flop synchroniser that changes only when the last two flops agree
`timescale 1ns/1ps
`default_nettype none
module tch_sync3
    import tch_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic out;
    } tch_sync_s;

    tch_sync_s st_q;
    tch_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.ff1 = din;
        st_d.ff2 = st_q.ff1;
        st_d.ff3 = st_q.ff2;
        if (st_q.ff2 == st_q.ff3) begin
            st_d.out = st_q.ff3;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.out;
endmodule : tch_sync3
`default_nettype wire

// [logic/tch_rdy_gate.sv]
// Sticky ready flag raised a few cycles after boot end, only when idle
`timescale 1ns/1ps
`default_nettype none
module tch_rdy_gate
    import tch_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic boot_done,
    input  wire logic busy,
    output logic      rdy
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       rdy;
    } tch_gate_s;

    tch_gate_s st_q;
    tch_gate_s st_d;

    always_comb begin
        st_d = st_q;
        if (boot_done && st_q.cnt != 4'hF) begin
            st_d.cnt = st_q.cnt + 4'h1;
        end
        // Never released again short of reconfiguration
        if (boot_done && st_q.cnt >= 4'(RDY_MIN_CYC) && !busy) begin
            st_d.rdy = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{cnt: CNT_RESET, rdy: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdy = st_q.rdy;
endmodule : tch_rdy_gate
`default_nettype wire

// [logic/tch_handoff.sv]
// Top of the two-stage configuration handoff: gating, drain completer, bus
`timescale 1ns/1ps
`default_nettype none
module tch_handoff
    import tch_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     core_reset_req,
    input  wire logic                     core_link_up,
    input  wire logic                     rx_valid,
    input  wire tch_rx_s                  rx_beat,
    output logic                          rx_ready,
    output tch_cpl_s                      cpl_out,
    input  wire logic                     cpl_ready,
    input  wire tch_crit_s                user_crit,
    output tch_crit_s                     core_crit,
    input  wire tch_icap_s                user_icap,
    output tch_icap_s                     icap_out,
    input  wire logic [31:0]              icap_rdata,
    output logic [31:0]                   user_icap_rdata,
    input  wire logic [STARTUP_DRV_W-1:0] user_startup_drv,
    output logic [STARTUP_DRV_W-1:0]      startup_drv,
    input  wire logic [STARTUP_OBS_W-1:0] startup_obs,
    output logic [STARTUP_OBS_W-1:0]      user_startup_obs,
    output logic                          user_clock,
    output logic                          user_reset,
    output logic                          user_lnk_up,
    output logic                          user_app_rdy,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tch_state_e                 st;
        logic                       cpl_pend;
        logic                       rx_ready;
        tch_cpl_s                   cpl;
        tch_crit_s                  crit;
        tch_icap_s                  icap;
        logic [31:0]                icap_rdata;
        logic [STARTUP_DRV_W-1:0]   su_drv;
        logic [STARTUP_OBS_W-1:0]   su_obs;
        logic                       reset;
        logic                       lnk_up;
        logic [31:0]                ctrl;
        logic [31:0]                wcount;
        logic                       aw_have;
        logic [7:0]                 awaddr;
        logic                       w_have;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } tch_top_s;

    tch_top_s st_q;
    tch_top_s st_d;
    logic     boot_done;
    logic     rdy;
    logic     busy;
    logic     rx_take;

    // Boot end flag comes from the startup primitive, another domain
    tch_sync3 u_boot_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (startup_obs[BOOT_FLAG_IDX]),
        .dout  (boot_done)
    );

    assign busy = (st_q.st != S_IDLE) && (st_q.st != S_OFF);

    tch_rdy_gate u_rdy_gate (
        .clock     (clock),
        .rst_n     (rst_n),
        .boot_done (boot_done),
        .busy      (busy),
        .rdy       (rdy)
    );

    assign rx_take = rx_valid && st_q.rx_ready;

    function automatic logic [31:0] status_word(input tch_top_s s, input logic r,
                                               input logic b);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ST_RDY_BIT] = r;
        w[ST_LNK_BIT] = s.lnk_up;
        w[ST_BOOT_BIT] = b;
        w[ST_STATE_LSB +: 3] = s.st;
        return w;
    endfunction : status_word

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge_strb

    always_comb begin
        st_d = st_q;
        // ------------------------------------------------------------
        // Drain completer
        // ------------------------------------------------------------
        st_d.icap.sel_n = 1'b1;
        st_d.icap.rd_n = 1'b1;
        unique case (st_q.st)
            S_IDLE: begin
                if (rdy) begin
                    st_d.st = S_OFF;
                end else if (rx_take) begin
                    unique case (rx_beat.kind)
                        K_MEM_RD: begin
                            // Any length is answered as a single zero dword
                            st_d.cpl.tag = rx_beat.tag;
                            st_d.cpl.req_id = rx_beat.req_id;
                            st_d.cpl.data = 32'h0000_0000;
                            st_d.cpl_pend = 1'b1;
                            st_d.st = rx_beat.last ? S_CPL : S_DROP;
                        end
                        K_MEM_WR: begin
                            // Bitstream only over BAR0 inside its aperture
                            if (rx_beat.bar0_hit && rx_beat.addr < BAR0_LIMIT) begin
                                st_d.st = rx_beat.last ? S_IDLE : S_WR;
                            end else begin
                                st_d.st = rx_beat.last ? S_IDLE : S_DROP;
                            end
                        end
                        K_VDM: begin
                            st_d.st = rx_beat.last ? S_IDLE : S_DROP;
                        end
                        K_OTHER: begin
                            st_d.st = rx_beat.last ? S_IDLE : S_DROP;
                        end
                    endcase
                end
            end
            S_WR: begin
                if (rx_take) begin
                    if (st_q.ctrl[CTRL_FWD_EN]) begin
                        st_d.icap.sel_n = 1'b0;
                        st_d.icap.rd_n = 1'b0;
                        st_d.icap.wdata = rx_beat.data;
                        st_d.wcount = st_q.wcount + 32'h0000_0001;
                    end
                    if (rx_beat.last) begin
                        st_d.st = S_IDLE;
                    end
                end
            end
            S_DROP: begin
                if (rx_take && rx_beat.last) begin
                    st_d.st = st_q.cpl_pend ? S_CPL : S_IDLE;
                end
            end
            S_CPL: begin
                st_d.cpl.valid = 1'b1;
                if (st_q.cpl.valid && cpl_ready) begin
                    st_d.cpl.valid = 1'b0;
                    st_d.cpl_pend = 1'b0;
                    st_d.st = S_IDLE;
                end
            end
            S_OFF: begin
                st_d.st = S_OFF;
            end
            default: begin
                st_d.st = S_IDLE;
            end
        endcase
        // Stop taking new requests once boot end is seen so handoff is clean
        st_d.rx_ready = ((st_d.st == S_IDLE) && !boot_done && !rdy)
                        || st_d.st == S_WR || st_d.st == S_DROP;

        // ------------------------------------------------------------
        // Handoff muxes and pass-through
        // ------------------------------------------------------------
        if (rdy) begin
            st_d.crit = user_crit;
            st_d.rx_ready = user_crit.rx_ready;
            st_d.icap = user_icap;
            st_d.su_drv = user_startup_drv;
        end else begin
            st_d.crit = '0;
            st_d.su_drv = '0;
        end
        st_d.icap_rdata = icap_rdata;
        st_d.su_obs = startup_obs;
        st_d.reset = core_reset_req;
        st_d.lnk_up = core_link_up;

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_have = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_have = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            unique case (st_q.awaddr)
                ADDR_CTRL: st_d.ctrl = merge_strb(st_q.ctrl, st_q.wdata, st_q.wstrb);
                ADDR_STATUS: st_d.bresp = RESP_OKAY;
                ADDR_WCOUNT: st_d.wcount = st_d.wcount - st_q.wcount; // Same-cycle word survives
                default: st_d.bresp = RESP_SLVERR;
            endcase
        end
        st_d.awready = !st_d.aw_have && !st_d.bvalid;
        st_d.wready = !st_d.w_have && !st_d.bvalid;
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_q.arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL: st_d.rdata = st_q.ctrl;
                ADDR_STATUS: st_d.rdata = status_word(st_q, rdy, boot_done);
                ADDR_WCOUNT: st_d.rdata = st_q.wcount;
                default: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.st <= S_IDLE;
            st_q.icap.sel_n <= 1'b1;
            st_q.icap.rd_n <= 1'b1;
            st_q.reset <= 1'b1;
            st_q.ctrl <= CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rx_ready = st_q.rx_ready;
    assign cpl_out = st_q.cpl;
    assign core_crit = st_q.crit;
    assign icap_out = st_q.icap;
    assign user_icap_rdata = st_q.icap_rdata;
    assign startup_drv = st_q.su_drv;
    assign user_startup_obs = st_q.su_obs;
    // Exported as-is; user logic talking to the core must run on it
    assign user_clock = clock;
    assign user_reset = st_q.reset;
    assign user_lnk_up = st_q.lnk_up;
    assign user_app_rdy = rdy;
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int A_MAX = 12;
    logic [4:0] boot_age;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boot_age <= 5'h00;
        end else if (boot_done && boot_age != 5'h1F) begin
            boot_age <= boot_age + 5'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_crit_gated: assert property (!rdy |=> core_crit == '0)
        else $error("critical input passed before ready");
    a_crit_follow: assert property (rdy |=> core_crit == $past(user_crit))
        else $error("critical input not from user after ready");
    a_rd_zero: assert property (cpl_out.valid |-> cpl_out.data == 32'h0000_0000)
        else $error("completion data not zero");
    a_cpl_hold: assert property (cpl_out.valid && !cpl_ready |=> cpl_out.valid)
        else $error("completion dropped before accepted");
    a_icap_fwd: assert property (st_q.st == S_WR && rx_take && st_q.ctrl[CTRL_FWD_EN] && !rdy
        |=> !icap_out.sel_n && icap_out.wdata == $past(rx_beat.data))
        else $error("bar0 write not forwarded");
    a_vdm_quiet: assert property (st_q.st == S_IDLE && rx_take && rx_beat.kind == K_VDM
        |=> !cpl_out.valid && icap_out.sel_n)
        else $error("vendor message caused action");
    a_off_stays: assert property (st_q.st == S_OFF |=> st_q.st == S_OFF)
        else $error("completer left inactive state");
    a_rdy_sticky: assert property (rdy |=> rdy)
        else $error("ready dropped");
    a_rdy_early: assert property ($rose(rdy) |-> boot_age > 5'(RDY_MIN_CYC))
        else $error("ready raised too early");
    a_rdy_late: assert property (boot_age == 5'h01 && !busy ##1 !busy [*2]
        |-> ##[0:A_MAX] rdy)
        else $error("ready not raised in time");
    a_rdy_idle: assert property ($rose(rdy) |-> !$past(busy))
        else $error("ready raised mid transaction");
    a_rst_out: assert property ($rose(core_reset_req) |=> user_reset)
        else $error("reset output not following core reset");
    a_lnk_out: assert property (user_lnk_up == $past(core_link_up))
        else $error("link up output mismatch");

    c_read_cpl: cover property (cpl_out.valid && cpl_ready);
    c_bitstream: cover property (!icap_out.sel_n && !rdy);
    c_handoff: cover property ($rose(rdy));
    c_axi_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : tch_handoff
`default_nettype wire

// [test/tch_user_model.sv]
// Far-side model: stage-two user logic clocked by the exported core clock
`timescale 1ns/1ps
`default_nettype none
module tch_user_model
    import tch_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rdy,
    output var tch_crit_s             crit,
    output var tch_icap_s             icap,
    output var logic [STARTUP_DRV_W-1:0] sdrv
);
    logic [31:0] cnt_q = 32'h0000_0000;

    always @(posedge clock) cnt_q <= cnt_q + 32'h0000_0001;

    // Unconfigured fabric wanders every cycle, so gating faults cannot hide
    always_comb begin
        if (rdy) begin
            crit = tch_crit_s'(6'h2d);
            icap = {2'b01, 32'hc0de_0001};
            sdrv = 8'h5a;
        end else begin
            crit = tch_crit_s'(~cnt_q[5:0]);
            icap = {cnt_q[1:0], ~cnt_q};
            sdrv = cnt_q[7:0];
        end
    end
endmodule : tch_user_model
`default_nettype wire

// [test/test_tch_handoff.sv]
// Self-checking bench for the two-stage configuration handoff
`timescale 1ns/1ps
`default_nettype none
module test_tch_handoff
    import tch_pkg::*;
;
    logic clock, rst_n, core_reset_req, core_link_up, rx_valid, rx_ready, cpl_ready;
    logic user_clock, user_reset, user_lnk_up, user_app_rdy, ok;
    tch_rx_s rx_beat;
    tch_cpl_s cpl_out;
    tch_crit_s user_crit, core_crit;
    tch_icap_s user_icap, icap_out;
    logic [31:0] icap_rdata, user_icap_rdata, s_axi_wdata, s_axi_rdata, icap_last, rd;
    logic [STARTUP_DRV_W-1:0] user_startup_drv, startup_drv;
    logic [STARTUP_OBS_W-1:0] startup_obs, user_startup_obs;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int num_errors = 0, compares = 0, icap_n = 0, n;

    tch_handoff DUT (.*);
    tch_user_model PM (.clock(user_clock), .rdy(user_app_rdy), .crit(user_crit),
                       .icap(user_icap), .sdrv(user_startup_drv));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Counts forwarded words; after handoff the user owns the port
    always @(negedge clock) begin
        if (icap_out.sel_n === 1'b0 && user_app_rdy === 1'b0) begin
            icap_n++;
            icap_last = icap_out.wdata;
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            $display("[FAIL] %0t seen %h exp %h", $time, s, e);
            num_errors++;
        end
    endtask : chk

    task automatic end_sim;
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    function automatic tch_rx_s hdr(tch_kind_e k, logic b, logic l, logic [31:0] d);
        hdr = '{k, b, l, 8'h3c, 16'h0100, 32'h0000_0040, d};
    endfunction : hdr

    // Ready is registered, so its value at the falling edge is what the next edge takes
    task automatic rx_send(input tch_rx_s b);
        logic r;
        rx_beat <= b;
        rx_valid <= 1'b1;
        do begin
            @(negedge clock) r = rx_ready;
            @(posedge clock);
        end while (r !== 1'b1);
    endtask : rx_send

    task automatic wait_cpl(output logic f);
        f = 1'b0;
        repeat (10) begin
            @(negedge clock);
            if (cpl_out.valid === 1'b1) begin
                f = 1'b1;
                chk(cpl_out.data, 32'h0000_0000);
                chk(cpl_out.tag, 8'h3c);
                chk(cpl_out.req_id, 16'h0100);
            end
        end
        // Back on the rising edge so the next beat is not offered half a cycle early
        @(posedge clock);
    endtask : wait_cpl

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (tb !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clock);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (tr !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        {rst_n, core_reset_req, core_link_up, rx_valid, rx_beat, icap_rdata, startup_obs,
         s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
         s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        cpl_ready = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge clock);
        chk(user_reset, 1);
        chk(user_app_rdy, 0);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk(core_crit, 0);
        chk(startup_drv, 0);
        rx_send(hdr(K_MEM_RD, 1'b0, 1'b1, 32'h0000_0000));
        rx_valid <= 1'b0;
        wait_cpl(ok);
        chk(ok, 1);
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b0, 32'h0000_0000));
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b0, 32'h1111_2222));
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b1, 32'h3333_4444));
        rx_send(hdr(K_VDM, 1'b0, 1'b1, 32'h0000_0000));
        rx_send(hdr(K_MEM_WR, 1'b0, 1'b0, 32'h0000_0000));
        rx_send(hdr(K_MEM_WR, 1'b0, 1'b1, 32'h5555_6666));
        rx_valid <= 1'b0;
        wait_cpl(ok);
        chk(ok, 0);
        chk(icap_n, 2);
        chk(icap_last, 32'h3333_4444);
        axi_rd(ADDR_WCOUNT, rd, rs);
        chk(rd, 2);
        axi_rd(ADDR_CTRL, rd, rs);
        chk(rd, CTRL_RESET);
        chk(rs, RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'h0000_0000, rs);
        chk(rs, RESP_OKAY);
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b0, 32'h0000_0000));
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b1, 32'h7777_8888));
        rx_valid <= 1'b0;
        axi_wr(ADDR_CTRL, CTRL_RESET, rs);
        rx_send(tch_rx_s'{K_MEM_WR, 1'b1, 1'b0, 8'h3c, 16'h0100, BAR0_LIMIT, 32'h0000_0000});
        rx_send(hdr(K_MEM_WR, 1'b1, 1'b1, 32'h9999_aaaa));
        rx_valid <= 1'b0;
        repeat (2) @(posedge clock);
        chk(icap_n, 2);
        chk(icap_last, 32'h3333_4444);
        axi_wr(ADDR_WCOUNT, 32'h0000_0000, rs);
        axi_rd(ADDR_WCOUNT, rd, rs);
        chk(rd, 0);
        axi_rd(8'h40, rd, rs);
        chk(rs, RESP_SLVERR);
        axi_wr(8'h40, 32'h0000_0000, rs);
        chk(rs, RESP_SLVERR);
        core_link_up <= 1'b1;
        core_reset_req <= 1'b1;
        icap_rdata <= 32'h89ab_cdef;
        startup_obs <= 5'h1e;
        repeat (3) @(posedge clock);
        chk(user_lnk_up, 1);
        chk(user_reset, 1);
        chk(user_icap_rdata, 32'h89ab_cdef);
        chk(user_startup_obs, 5'h1e);
        core_reset_req <= 1'b0;
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd[ST_LNK_BIT], 1);
        chk(user_reset, 0);
        chk(user_app_rdy, 0);
        startup_obs <= 5'h1f;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (user_app_rdy !== 1'b1 && n < 40);
        chk(n >= 7 && n <= 17, 1);
        repeat (3) @(posedge clock);
        chk(core_crit, 6'h2d);
        chk(startup_drv, 8'h5a);
        chk(icap_out.wdata, 32'hc0de_0001);
        rx_send(hdr(K_MEM_RD, 1'b0, 1'b1, 32'h0000_0000));
        rx_valid <= 1'b0;
        wait_cpl(ok);
        chk(ok, 0);
        chk(user_app_rdy, 1);
        end_sim;
    end

    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_sim;
    end
endmodule : test_tch_handoff
`default_nettype wire
